// *** src/ieesrq_top.sv ***
// service request and parallel poll logic with axi4-lite control
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module ieesrq_top (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   // bus lines, true means asserted
   input  wire logic        atn,
   input  wire logic        eoi,
   input  wire logic [7:0]  dio_in,
   input  wire logic        cmd_strobe,
   input  wire logic        is_controller,
   // bus drive, enable low means pull low
   output logic [7:0]       dio_oe_n,
   output logic             srq_oe_n,
   // axi4-lite write address
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef enum logic [1:0] {IDLE, CONFIG_SEEN} ieesrq_cfg_t;

   ieesrq_cfg_t cfg_state;
   ieesrq_cfg_t next_cfg_state;
   logic [31:0] ctrl;
   logic        srq;
   logic        listener;
   logic        spoll_mode;
   logic        talker;
   logic        pp_enabled;
   logic        pp_sense;
   logic [2:0]  pp_line;
   logic        req_prev;
   logic        aw_held;
   logic        w_held;
   logic [3:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;

   ieesrq_resp_if resp ();

   // bus command decode
   wire       cmd_take    = clk_en && cmd_strobe && atn;
   wire [7:0] cmd         = dio_in;
   wire [4:0] my_addr     = ctrl[ieesrq_pkg::CTRL_ADDR_LSB +: 5];
   wire       is_unl      = cmd == ieesrq_pkg::CMD_UNLISTEN;
   wire       is_my_lsn   = (cmd[7:5] == ieesrq_pkg::LISTEN_GROUP) && (cmd[4:0] == my_addr) && !is_unl;
   wire       is_talk     = cmd[7:5] == ieesrq_pkg::TALK_GROUP && cmd[4:0] != 5'h1F;
   wire       is_my_talk  = is_talk && cmd[4:0] == my_addr;
   wire       is_cfg      = cmd == ieesrq_pkg::CMD_CONFIGURE;
   wire       is_enable   = cmd[7:4] == ieesrq_pkg::ENABLE_PATTERN;
   wire       is_disable  = cmd == ieesrq_pkg::CMD_DISABLE;
   wire       do_enable   = cmd_take && listener && cfg_state == CONFIG_SEEN && is_enable;
   wire       do_disable  = cmd_take && listener && cfg_state == CONFIG_SEEN && is_disable;
   wire       poll_active = atn && eoi;
   // a serial poll read: not atn, spoll mode, addressed talker, byte strobed out
   wire       spolled     = clk_en && cmd_strobe && !atn && spoll_mode && talker;

   always_comb begin
      next_cfg_state = cfg_state;
      if (cmd_take) begin
         unique case (cfg_state)
            IDLE:        next_cfg_state = is_cfg ? CONFIG_SEEN : IDLE;
            CONFIG_SEEN: next_cfg_state = is_cfg ? CONFIG_SEEN : IDLE;
            default:     next_cfg_state = IDLE;
         endcase
      end
   end

   // addressing state, one short block per flag
   wire       set_lsn     = cmd_take && is_my_lsn;
   wire       clr_lsn     = cmd_take && is_unl;
   wire       new_talk    = cmd_take && is_talk;
   wire       spoll_on    = cmd_take && cmd == ieesrq_pkg::CMD_SPOLL_EN;
   wire       spoll_off   = cmd_take && cmd == ieesrq_pkg::CMD_SPOLL_DIS;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_state <= IDLE;
      end else if (clk_en) begin
         cfg_state <= next_cfg_state;
      end
   end

   // unlisten wins so a stray own listen byte in the same strobe cannot re-arm
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         listener <= 1'b0;
      end else if (clk_en) begin
         if (clr_lsn) begin
            listener <= 1'b0;
         end else if (set_lsn) begin
            listener <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         talker <= 1'b0;
      end else if (clk_en) begin
         if (new_talk) begin
            talker <= is_my_talk;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         spoll_mode <= 1'b0;
      end else if (clk_en) begin
         if (spoll_on) begin
            spoll_mode <= 1'b1;
         end else if (spoll_off) begin
            spoll_mode <= 1'b0;
         end
      end
   end

   // remote poll configuration; held disabled from reset
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pp_enabled <= 1'b0;
         pp_sense   <= 1'b0;
         pp_line    <= 3'h0;
      end else if (clk_en) begin
         if (do_enable) begin
            pp_enabled <= 1'b1;
            pp_sense   <= cmd[ieesrq_pkg::SENSE_BIT];
            pp_line    <= cmd[2:0];
         end else if (do_disable) begin
            pp_enabled <= 1'b0;
         end
      end
   end

   // service request: set by a rising request bit, held until withdrawn or, with auto-clear set, polled
   wire req_rise = ctrl[ieesrq_pkg::CTRL_REQ] && !req_prev;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         srq      <= 1'b0;
         req_prev <= 1'b0;
      end else if (clk_en) begin
         req_prev <= ctrl[ieesrq_pkg::CTRL_REQ];
         // a new request in the same cycle as a poll wins
         if (req_rise) srq <= 1'b1;
         else if (spolled && ctrl[ieesrq_pkg::CTRL_AUTOCLR]) srq <= 1'b0;
         else if (!ctrl[ieesrq_pkg::CTRL_REQ]) srq <= 1'b0;
      end
   end
   assign srq_oe_n = !srq;

   assign resp.enabled  = pp_enabled;
   assign resp.sense    = pp_sense;
   assign resp.line_sel = pp_line;
   assign resp.hw_mode  = ctrl[ieesrq_pkg::CTRL_HWMODE];
   assign resp.bus_addr = my_addr;
   assign resp.need     = ctrl[ieesrq_pkg::CTRL_NEED] | srq;
   assign resp.is_ctrl  = is_controller;

   ieesrq_poll_drv u_poll (
      .ref_clk     (ref_clk),
      .reset_n     (reset_n),
      .clk_en      (clk_en),
      .poll_active (poll_active),
      .cfg         (resp),
      .dio_oe_n    (dio_oe_n)
   );

   // axi4-lite slave: one write and one read in flight
   wire do_write  = aw_held && w_held && !s_axi_bvalid;
   wire wr_ctrl   = aw_addr == ieesrq_pkg::REG_CTRL;
   wire wr_ok     = wr_ctrl || aw_addr == ieesrq_pkg::REG_STATUS || aw_addr == ieesrq_pkg::REG_PPCFG;
   wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire [31:0] status_word = {26'h0, spoll_mode, talker, listener, cfg_state == CONFIG_SEEN, is_controller, srq};
   wire [31:0] ppcfg_word  = {27'h0, pp_enabled, pp_sense, pp_line};
   wire        rd_ok   = s_axi_araddr == ieesrq_pkg::REG_CTRL || s_axi_araddr == ieesrq_pkg::REG_STATUS
                         || s_axi_araddr == ieesrq_pkg::REG_PPCFG;
   wire [31:0] rd_word = s_axi_araddr == ieesrq_pkg::REG_CTRL   ? ctrl :
                         s_axi_araddr == ieesrq_pkg::REG_STATUS ? status_word :
                         s_axi_araddr == ieesrq_pkg::REG_PPCFG  ? ppcfg_word : 32'h0;

   // readies fall with clk_en so no beat is seen as taken while the slave is frozen
   assign s_axi_awready = clk_en && !aw_held;
   assign s_axi_wready  = clk_en && !w_held;
   assign s_axi_arready = clk_en && !s_axi_rvalid;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held <= 1'b0;
         aw_addr <= 4'h0;
      end else if (clk_en) begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         w_held <= 1'b0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else if (clk_en) begin
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   wire [31:0] next_ctrl = (ctrl & ~wmask) | (w_data & wmask);
   wire        ctrl_we   = clk_en && do_write && wr_ctrl;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= ieesrq_pkg::CTRL_RESET;
      end else if (ctrl_we) begin
         ctrl <= next_ctrl;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= ieesrq_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? ieesrq_pkg::RESP_OKAY : ieesrq_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= ieesrq_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? ieesrq_pkg::RESP_OKAY : ieesrq_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   srq_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      srq && ctrl[ieesrq_pkg::CTRL_REQ] && !spolled |=> srq) else $error("request dropped early");
   srq_autoclr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      srq && spolled && ctrl[ieesrq_pkg::CTRL_AUTOCLR] && !req_rise |=> !srq)
      else $error("serial poll did not release request");
   enable_store_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      do_enable |=> pp_enabled && pp_line == $past(cmd[2:0]) && pp_sense == $past(cmd[3]))
      else $error("enable byte not stored");
   bad_pattern_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      cmd_take && cmd[7:4] != ieesrq_pkg::ENABLE_PATTERN && !is_disable |=> $stable(pp_enabled))
      else $error("non-enable byte changed config");
   disable_cmd_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      do_disable |=> !pp_enabled) else $error("disable not honoured");
   sense_drive_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && poll_active && !is_controller && !resp.hw_mode && pp_enabled && pp_sense == resp.need
      |=> !dio_oe_n[$past(pp_line)]) else $error("enabled response line not driven");
   reset_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(reset_n) |-> !pp_enabled) else $error("config enabled after reset");

   aw_once_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("write address taken twice");
   rd_once_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read address not answered");
   b_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   r_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   ctrl_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ctrl_we |=> ctrl == $past(next_ctrl)) else $error("control write lost");
   ctrl_keep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !ctrl_we |=> $stable(ctrl)) else $error("control changed without a write");
   state_freeze_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !clk_en |=> $stable(srq) && $stable(listener) && $stable(pp_enabled) && $stable(cfg_state))
      else $error("state moved while frozen");
   srq_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && req_rise |=> srq) else $error("request not raised");
   srq_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && !ctrl[ieesrq_pkg::CTRL_REQ] |=> !srq) else $error("withdrawn request still raised");
   listen_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      set_lsn |=> listener) else $error("listen address ignored");
   unlisten_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clr_lsn |=> !listener) else $error("unlisten ignored");
   talk_track_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      new_talk |=> talker == $past(is_my_talk)) else $error("talk address mistracked");
   spoll_on_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      spoll_on |=> spoll_mode) else $error("serial poll mode not entered");
   spoll_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      spoll_off |=> !spoll_mode) else $error("serial poll mode not left");
   cfg_seen_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      cmd_take && is_cfg |=> cfg_state == CONFIG_SEEN) else $error("configure command missed");
   enable_keep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      cmd_take && !do_enable |=> $stable(pp_line) && $stable(pp_sense))
      else $error("response changed without enable");
endmodule

// *** src/ieesrq_pkg.sv ***
// shared constants for the service-request and parallel-poll block
package ieesrq_pkg;
   // command bytes seen with attention asserted
   localparam logic [7:0] CMD_CONFIGURE   = 8'h05;
   localparam logic [7:0] CMD_DISABLE     = 8'h70;
   localparam logic [7:0] CMD_UNLISTEN    = 8'h3F;
   localparam logic [7:0] CMD_SPOLL_EN    = 8'h18;
   localparam logic [7:0] CMD_SPOLL_DIS   = 8'h19;
   localparam logic [2:0] LISTEN_GROUP    = 3'h1;
   localparam logic [2:0] TALK_GROUP      = 3'h2;
   localparam logic [3:0] ENABLE_PATTERN  = 4'h6;
   localparam int         SENSE_BIT       = 3;
   localparam logic [4:0] ADDR_RESET      = 5'h00;
   localparam logic [4:0] HW_ADDR_MAX     = 5'h07;
   // axi4-lite register map
   localparam logic [3:0] REG_CTRL        = 4'h0;
   localparam logic [3:0] REG_STATUS      = 4'h4;
   localparam logic [3:0] REG_PPCFG       = 4'h8;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;
   // control register fields
   localparam int         CTRL_REQ        = 0;
   localparam int         CTRL_AUTOCLR    = 1;
   localparam int         CTRL_HWMODE     = 2;
   localparam int         CTRL_NEED       = 3;
   localparam int         CTRL_ADDR_LSB   = 8;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0002;
endpackage

// *** src/ieesrq_resp_if.sv ***
// response settings passed from the decoder to the poll driver
`timescale 1ns/1ps
interface ieesrq_resp_if;
   logic       enabled;
   logic       sense;
   logic [2:0] line_sel;
   logic       hw_mode;
   logic [4:0] bus_addr;
   logic       need;
   logic       is_ctrl;
   modport src (output enabled, sense, line_sel, hw_mode, bus_addr, need, is_ctrl);
   modport dst (input enabled, sense, line_sel, hw_mode, bus_addr, need, is_ctrl);
endinterface

// *** src/ieesrq_poll_drv.sv ***
// parallel poll response driver
`timescale 1ns/1ps
module ieesrq_poll_drv (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       clk_en,
   // bus state
   input  wire logic       poll_active,
   // settings
   ieesrq_resp_if.dst      cfg,
   // data line drive, enable low means drive low
   output logic [7:0]      dio_oe_n
);
   wire       hw_ok     = cfg.hw_mode && (cfg.bus_addr <= ieesrq_pkg::HW_ADDR_MAX);
   wire [2:0] hw_line   = 3'h7 - cfg.bus_addr[2:0];
   wire       hw_pull   = cfg.need;
   wire       sw_pull   = (cfg.sense == cfg.need);
   wire       answer    = poll_active && !cfg.is_ctrl && (hw_ok || (!cfg.hw_mode && cfg.enabled));
   wire [2:0] use_line  = cfg.hw_mode ? hw_line : cfg.line_sel;
   wire       pull      = cfg.hw_mode ? hw_pull : sw_pull;
   wire [7:0] next_oe_n = (answer && pull) ? ~(8'h01 << use_line) : 8'hFF;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         dio_oe_n <= 8'hFF;
      end else if (clk_en) begin
         dio_oe_n <= next_oe_n;
      end
   end

   one_line_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $countones(~dio_oe_n) <= 1) else $error("more than one poll line driven");
   ctrl_silent_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && cfg.is_ctrl |=> dio_oe_n == 8'hFF) else $error("controller answered poll");
   poll_end_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && !poll_active |=> dio_oe_n == 8'hFF) else $error("line driven outside poll");
   hw_line_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      clk_en && poll_active && !cfg.is_ctrl && cfg.hw_mode && cfg.need && cfg.bus_addr == 5'h00
      |=> dio_oe_n == 8'h7F) else $error("address zero must use top line");
endmodule

// *** testbench/ieesrq_ctrl_model.sv ***
// active controller model: addressing, command bytes and parallel polls
`timescale 1ns/1ps
module ieesrq_ctrl_model (
   // clock
   input  wire logic       ref_clk,
   // response from the device, low means pulled
   input  wire logic [7:0] dio_oe_n,
   // bus lines driven by the controller
   output logic            atn,
   output logic            eoi,
   output logic [7:0]      dio_in,
   output logic            cmd_strobe
);
   initial begin
      atn        = 1'b0;
      eoi        = 1'b0;
      dio_in     = 8'hA5;
      cmd_strobe = 1'b0;
   end
   task automatic send(input logic [7:0] b, input logic a);
      @(posedge ref_clk);
      atn        <= a;
      dio_in     <= b;
      cmd_strobe <= 1'b1;
      @(posedge ref_clk);
      cmd_strobe <= 1'b0;
      // released lines must not keep showing the last byte
      dio_in     <= ~b;
   endtask
   // own talk address, unlisten, then the target listen address
   task automatic address(input logic [4:0] tgt);
      send(8'h40, 1'b1);
      send(8'h3F, 1'b1);
      send(8'h20 + {3'h0, tgt}, 1'b1);
   endtask
   // shared lines are read as one byte, line 0 in the lsb
   task automatic poll(output logic [7:0] r);
      @(posedge ref_clk);
      atn <= 1'b1;
      eoi <= 1'b1;
      repeat (3) @(posedge ref_clk);
      r = ~dio_oe_n;
      eoi <= 1'b0;
      atn <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
endmodule

// *** testbench/ieesrq_top_tb.sv ***
// self-checking bench for the service request and parallel poll block
`timescale 1ns/1ps
module ieesrq_top_tb;
   logic        ref_clk, reset_n, clk_en, is_controller;
   logic        atn, eoi, cmd_strobe, srq_oe_n;
   logic [7:0]  dio_in, dio_oe_n, pr;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          num_errors, check_count, k, n;
   ieesrq_top i_dut (.ref_clk, .reset_n, .clk_en, .atn, .eoi, .dio_in, .cmd_strobe, .is_controller,
      .dio_oe_n, .srq_oe_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   ieesrq_ctrl_model i_ctrl (.ref_clk, .dio_oe_n, .atn, .eoi, .dio_in, .cmd_strobe);
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic hung();
      num_errors++;
      tally_and_finish();
   endtask
   function automatic logic [31:0] ctrl(input logic nd, hw, ac, rq, input logic [4:0] a);
      return {19'h0, a, 4'h0, nd, hw, ac, rq};
   endfunction
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge ref_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge ref_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            s_axi_bready <= 1'b0;
            chk(s_axi_bresp, er);
            break;
         end
      end
      if (i == 50) hung();
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      int i;
      @(posedge ref_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge ref_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            s_axi_rready <= 1'b0;
            chk(s_axi_rdata, ed);
            chk(s_axi_rresp, er);
            break;
         end
      end
      if (i == 50) hung();
   endtask
   task automatic cfg(input logic [7:0] b);
      i_ctrl.address(5'h05);
      i_ctrl.send(ieesrq_pkg::CMD_CONFIGURE, 1'b1);
      i_ctrl.send(b, 1'b1);
   endtask
   initial begin
      {reset_n, is_controller, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      clk_en = 1'b1;
      s_axi_wstrb = 4'hF;
      num_errors = 0;
      check_count = 0;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(ieesrq_pkg::REG_CTRL, ieesrq_pkg::CTRL_RESET, ieesrq_pkg::RESP_OKAY);
      rd(ieesrq_pkg::REG_PPCFG, 32'h0, ieesrq_pkg::RESP_OKAY);
      i_ctrl.poll(pr);
      chk(pr, 32'h0);
      rd(4'hC, 32'h0, ieesrq_pkg::RESP_SLVERR);
      wr(4'hC, 32'hFFFF_FFFF, ieesrq_pkg::RESP_SLVERR);
      wr(ieesrq_pkg::REG_PPCFG, 32'h0000_001F, ieesrq_pkg::RESP_OKAY);
      rd(ieesrq_pkg::REG_PPCFG, 32'h0, ieesrq_pkg::RESP_OKAY);
      rd(ieesrq_pkg::REG_CTRL, ieesrq_pkg::CTRL_RESET, ieesrq_pkg::RESP_OKAY);
      $display("test reset and map done");
      wr(ieesrq_pkg::REG_CTRL, ctrl(1'b0, 1'b0, 1'b1, 1'b0, 5'h05), ieesrq_pkg::RESP_OKAY);
      for (k = 0; k < 16; k++) begin
         cfg(8'h60 + 8'(k));
         rd(ieesrq_pkg::REG_PPCFG, 32'h10 + 32'(k), ieesrq_pkg::RESP_OKAY);
         for (n = 0; n < 2; n++) begin
            wr(ieesrq_pkg::REG_CTRL, ctrl(n[0], 1'b0, 1'b1, 1'b0, 5'h05), ieesrq_pkg::RESP_OKAY);
            i_ctrl.poll(pr);
            chk(pr, (k[3] == n[0]) ? (8'h01 << k[2:0]) : 8'h00);
            chk(dio_oe_n, 8'hFF);
         end
      end
      $display("test sixteen settings done");
      cfg(8'h50);
      cfg(8'hE6);
      rd(ieesrq_pkg::REG_PPCFG, 32'h1F, ieesrq_pkg::RESP_OKAY);
      i_ctrl.send(ieesrq_pkg::CMD_UNLISTEN, 1'b1);
      i_ctrl.send(ieesrq_pkg::CMD_CONFIGURE, 1'b1);
      i_ctrl.send(8'h61, 1'b1);
      rd(ieesrq_pkg::REG_PPCFG, 32'h1F, ieesrq_pkg::RESP_OKAY);
      cfg(ieesrq_pkg::CMD_DISABLE);
      i_ctrl.poll(pr);
      chk(pr, 32'h0);
      $display("test refusal and disable done");
      cfg(8'h68);
      is_controller <= 1'b1;
      i_ctrl.poll(pr);
      chk(pr, 32'h0);
      is_controller <= 1'b0;
      i_ctrl.poll(pr);
      chk(pr, 32'h01);
      cfg(ieesrq_pkg::CMD_DISABLE);
      $display("test controller done");
      // one fixed responder per line, then address 8 which has no line
      for (k = 0; k < 9; k++) begin
         for (n = 0; n < 2; n++) begin
            wr(ieesrq_pkg::REG_CTRL, ctrl(n[0], 1'b1, 1'b1, 1'b0, 5'(k)), ieesrq_pkg::RESP_OKAY);
            i_ctrl.poll(pr);
            chk(pr, (n == 1 && k < 8) ? (8'h80 >> k) : 8'h00);
         end
      end
      $display("test fixed response done");
      wr(ieesrq_pkg::REG_CTRL, ctrl(1'b0, 1'b0, 1'b1, 1'b1, 5'h05), ieesrq_pkg::RESP_OKAY);
      repeat (20) @(posedge ref_clk);
      chk(srq_oe_n, 1'b0);
      rd(ieesrq_pkg::REG_STATUS, 32'h09, ieesrq_pkg::RESP_OKAY);
      clk_en <= 1'b0;
      i_ctrl.send(ieesrq_pkg::CMD_UNLISTEN, 1'b1);
      clk_en <= 1'b1;
      rd(ieesrq_pkg::REG_STATUS, 32'h09, ieesrq_pkg::RESP_OKAY);
      i_ctrl.send(8'h45, 1'b1);
      i_ctrl.send(ieesrq_pkg::CMD_SPOLL_EN, 1'b1);
      i_ctrl.send(8'h40, 1'b0);
      repeat (3) @(posedge ref_clk);
      chk(srq_oe_n, 1'b1);
      wr(ieesrq_pkg::REG_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b0, 5'h05), ieesrq_pkg::RESP_OKAY);
      wr(ieesrq_pkg::REG_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b1, 5'h05), ieesrq_pkg::RESP_OKAY);
      i_ctrl.send(8'h40, 1'b0);
      repeat (3) @(posedge ref_clk);
      chk(srq_oe_n, 1'b0);
      i_ctrl.send(ieesrq_pkg::CMD_SPOLL_DIS, 1'b1);
      wr(ieesrq_pkg::REG_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b0, 5'h05), ieesrq_pkg::RESP_OKAY);
      repeat (3) @(posedge ref_clk);
      chk(srq_oe_n, 1'b1);
      $display("test service request done");
      tally_and_finish();
   end
endmodule
